// file: blpf_pkg.sv
// Purpose: constants shared by the byte link power and filter block
// Assumes: Avalon-MM word addressing of 32-bit registers
// Notes:   offsets are word indices
package blpf_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [1:0] BLPF_ADDR_CTRL1  = 2'h0;
  localparam logic [1:0] BLPF_ADDR_CTRL2  = 2'h1;
  localparam logic [1:0] BLPF_ADDR_VECTOR = 2'h2;
  localparam logic [1:0] BLPF_ADDR_STATUS = 2'h3;

  // link_control_one fields
  localparam int BLPF_C1_WAIT_SEL = 0;
  // link_control_two fields
  localparam int BLPF_C2_DIGITAL_LOOP_SELECT    = 0;
  localparam int BLPF_C2_ANALOG_LOOP_SELECT    = 1;
  // status fields
  localparam int BLPF_ST_MODE_LO  = 0;
  localparam int BLPF_ST_FILT     = 2;
  localparam int BLPF_ST_IDLE     = 3;
  localparam int BLPF_ST_CNT_LO   = 4;

  // ********************************************************
  // state vector codes
  // ********************************************************
  localparam logic [7:0] BLPF_VEC_NONE   = 8'h00;
  localparam logic [7:0] BLPF_VEC_WAKEUP = 8'h20;

  // ********************************************************
  // filter
  // ********************************************************
  localparam int         BLPF_CNT_W   = 4;
  localparam logic [3:0] BLPF_CNT_MAX = 4'hF;
  localparam logic [3:0] BLPF_CNT_MIN = 4'h0;

  // passive idle period before rejoining, in microseconds
  localparam int BLPF_IDLE_US  = 300;
  localparam int BLPF_CLK_MHZ  = 50;
  localparam int BLPF_IDLE_CYC = BLPF_IDLE_US * BLPF_CLK_MHZ;

  typedef enum logic [1:0] {
    BLPF_RUN,
    BLPF_WAIT,
    BLPF_STOP
  } blpf_mode_type;

endpackage

// file: blpf_link_power.sv
// Purpose: power modes, loopback and receive noise filter of a byte link
// Assumes: filter clock enable derived from ref_clk; passive bus is low
// Notes:   frame protocol handler sits outside this block
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps

// What this block does
// - wait select clear plus WAIT enters wait
// - wait mode drives nothing; rising edge wakes
// - wait wakeup raises interrupt, message still received
// - select set plus WAIT/STOP enters stop
// - stop wakeup raises non-maskable vector 20 hex
// - stop wakeup shown as top vector
// - power modes never change control register values; stop wakeup sets the vector
// - any network activity leaves low power, except in loopback
// - full stop: CPU restarts first, message unreliable
// - detach: flags clear, loopback, no wakeup
// - digital loop ties transmit to receive internally
// - after analog loop wait for idle bus
// - sample on rising, step on falling
// - count up high, down low, 0 to 15
// - at 15 latch one, no overflow
// - at 0 latch zero, no underflow
// - latch holds until opposite end reached
// - filter delay 15 to 16 periods
// - longer noise passes to symbol checker
module blpf_link_power
  import blpf_pkg::*;
#(
  parameter int FILT_DIV  = 48,
  parameter int IDLE_CYC  = BLPF_IDLE_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // cpu power events
  input  wire logic        cpu_wait_exec,
  input  wire logic        cpu_stop_exec,
  output logic             wake_irq,
  output logic             wake_nmi,
  output logic             link_clk_run,
  // protocol handler side
  input  wire logic        tx_data_int,
  output logic             rx_filtered,
  // transceiver pins
  output logic             tx_digital_out,
  input  wire logic        rx_digital_in
);

  // ********************************************************
  // parameter checks
  // ********************************************************
  // the divider needs two distinct phases, so two cycles at least;
  // an odd divider is served, the falling phase then sits early
  initial begin
    if (FILT_DIV < 2) $error("FILT_DIV must be at least 2");
    if (IDLE_CYC < 1) $error("IDLE_CYC must be at least 1");
  end

  // ********************************************************
  // registers
  // ********************************************************
  logic          stop_on_wait_select_q;
  logic          digital_loop_select_q;
  logic          analog_loop_select_q;
  logic [7:0]    link_state_vector_q;
  blpf_mode_type mode_q;
  logic          rd_pend_q;
  logic          vec_read;
  // idle gate flag, read by the transmit mux below
  logic          idle_wait_q;

  // ********************************************************
  // register bus
  // ********************************************************
  // writes complete at once; reads take one wait state so that the
  // status snapshot is a flop, never a path straight from the filter

  // single-cycle wait so readdata comes from a flop
  assign avs_waitrequest = (avs_read & ~rd_pend_q);
  assign vec_read = avs_read & rd_pend_q & (avs_address == BLPF_ADDR_VECTOR);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= avs_read & ~rd_pend_q;
    end
  end

  // writes never touched by mode transitions
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stop_on_wait_select_q <= 1'b0;
      digital_loop_select_q <= 1'b0;
      analog_loop_select_q  <= 1'b0;
    end else if (avs_write) begin
      unique case (avs_address)
        BLPF_ADDR_CTRL1: begin
          stop_on_wait_select_q <= avs_writedata[BLPF_C1_WAIT_SEL];
        end
        BLPF_ADDR_CTRL2: begin
          digital_loop_select_q <= avs_writedata[BLPF_C2_DIGITAL_LOOP_SELECT];
          analog_loop_select_q  <= avs_writedata[BLPF_C2_ANALOG_LOOP_SELECT];
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************
  // filter clock: rising and falling phases of a divided clock
  // ********************************************************
  localparam int DIV_W = $clog2(FILT_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(FILT_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(FILT_DIV / 2 - 1);

  logic [DIV_W-1:0] div_q;
  logic             fclk_rise;
  logic             fclk_fall;

  // clocks halted in stop mode
  assign link_clk_run = (mode_q != BLPF_STOP);
  assign fclk_rise = link_clk_run & (div_q == DIV_LAST);
  assign fclk_fall = link_clk_run & (div_q == DIV_HALF);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_q <= '0;
    end else if (link_clk_run) begin
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
    end
  end

  // ********************************************************
  // loopback routing
  // ********************************************************
  logic rx_raw;

  // passive level out while looped, waiting or still gated for idle;
  // analog loop alone leaves the transmit path untouched
  assign tx_digital_out = (digital_loop_select_q || idle_wait_q
                           || mode_q != BLPF_RUN) ? 1'b0
                        : tx_data_int;
  assign rx_raw = digital_loop_select_q ? tx_data_int : rx_digital_in;

  // ********************************************************
  // receive noise filter
  // ********************************************************
  logic                  samp_q;
  logic [BLPF_CNT_W-1:0] cnt_q;

  // sample and step live on different phases of the divided clock,
  // so a sample never feeds the counter in the cycle it is taken;
  // the latch follows the end points only, giving hysteresis
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      samp_q <= 1'b0;
    end else if (fclk_rise) begin
      samp_q <= rx_raw;
    end
  end

  // delay 15 to 16 filter periods falls out of saturation
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt_q <= BLPF_CNT_MIN;
    end else if (fclk_fall) begin
      if (samp_q && cnt_q != BLPF_CNT_MAX) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (!samp_q && cnt_q != BLPF_CNT_MIN) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // pulses beyond the delay pass on to the symbol decoder
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_filtered <= 1'b0;
    end else if (cnt_q == BLPF_CNT_MAX) begin
      rx_filtered <= 1'b1;
    end else if (cnt_q == BLPF_CNT_MIN) begin
      rx_filtered <= 1'b0;
    end
  end

  // ********************************************************
  // idle gate after analog loopback
  // ********************************************************
  localparam int IDLE_W = $clog2(IDLE_CYC + 1);
  localparam logic [IDLE_W-1:0] IDLE_END = IDLE_W'(IDLE_CYC);

  // any active filtered level restarts the count, so only an
  // unbroken passive span ends the gate
  logic              analog_loop_select_d1_q;
  logic [IDLE_W-1:0] idle_cnt_q;
  logic              link_active;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      analog_loop_select_d1_q  <= 1'b0;
      idle_wait_q <= 1'b0;
      idle_cnt_q  <= '0;
    end else begin
      analog_loop_select_d1_q <= analog_loop_select_q;
      if (analog_loop_select_d1_q && !analog_loop_select_q) begin
        idle_wait_q <= 1'b1;
        idle_cnt_q  <= '0;
      end else if (idle_wait_q) begin
        if (rx_filtered) begin
          idle_cnt_q <= '0;
        end else if (idle_cnt_q == IDLE_END) begin
          idle_wait_q <= 1'b0;
        end else begin
          idle_cnt_q <= idle_cnt_q + 1'b1;
        end
      end
    end
  end

  // transmit stays passive until idle seen
  assign link_active = ~idle_wait_q & ~analog_loop_select_q;

  // ********************************************************
  // power mode control
  // ********************************************************
  logic detached;
  logic wake_edge;
  logic rx_prev_q;

  // edge memory resets to the passive level, so no false wakeup
  // follows reset; loopback masks wakeups to detach the node

  // raw pin watched so a halted filter still wakes
  assign detached  = digital_loop_select_q | analog_loop_select_q;
  assign wake_edge = rx_digital_in & ~rx_prev_q & ~detached;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_digital_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_q <= BLPF_RUN;
    end else begin
      unique case (mode_q)
        BLPF_RUN: begin
          if (stop_on_wait_select_q && (cpu_wait_exec || cpu_stop_exec)) begin
            mode_q <= BLPF_STOP;
          end else if (!stop_on_wait_select_q && cpu_wait_exec) begin
            mode_q <= BLPF_WAIT;
          end
        end
        BLPF_WAIT: begin
          if (wake_edge) begin
            mode_q <= BLPF_RUN;
          end
        end
        BLPF_STOP: begin
          if (wake_edge) begin
            mode_q <= BLPF_RUN;
          end
        end
      endcase
    end
  end

  // filter keeps running in wait so the waking message is kept
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wake_irq <= 1'b0;
      wake_nmi <= 1'b0;
    end else begin
      wake_irq <= (mode_q == BLPF_WAIT) & wake_edge;
      wake_nmi <= (mode_q == BLPF_STOP) & wake_edge;
    end
  end

  // wakeup code held until software reads the vector; set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      link_state_vector_q <= BLPF_VEC_NONE;
    end else if (mode_q == BLPF_STOP && wake_edge) begin
      link_state_vector_q <= BLPF_VEC_WAKEUP;
    end else if (vec_read) begin
      link_state_vector_q <= BLPF_VEC_NONE;
    end
  end

  // ********************************************************
  // read data
  // ********************************************************
  // loaded in the first read cycle and held until the next read;
  // unused upper bits always read zero
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_readdata <= '0;
    end else if (avs_read && !rd_pend_q) begin
      unique case (avs_address)
        BLPF_ADDR_CTRL1: avs_readdata <= {31'h0, stop_on_wait_select_q};
        BLPF_ADDR_CTRL2: avs_readdata <= {30'h0, analog_loop_select_q,
                                          digital_loop_select_q};
        BLPF_ADDR_VECTOR: avs_readdata <= {24'h0, link_state_vector_q};
        BLPF_ADDR_STATUS: avs_readdata <= {24'h0, cnt_q, link_active, rx_filtered,
                                           mode_q};
      endcase
    end
  end

endmodule // blpf_link_power

// file: blpf_xcvr_model.sv
// Purpose: behavioural off-chip transceiver on the digital pins
// Assumes: passive bus is low through a pull-down
// Notes:   slow adds line delay on the receive path
`timescale 1ns/10ps
module blpf_xcvr_model (
  // clock
  input  wire logic ref_clk,
  // bench control
  input  wire logic bus_act,
  input  wire logic slow,
  // digital pins
  input  wire logic tx_digital_out,
  output logic      rx_digital_in
);
  logic [2:0] line_q = 3'h0;
  // wired-or bus echoes our own drive back to the receiver
  always_ff @(posedge ref_clk) begin
    line_q <= {line_q[1:0], bus_act | tx_digital_out};
  end
  assign rx_digital_in = slow ? line_q[2] : line_q[0];
endmodule // blpf_xcvr_model

// file: blpf_link_power_chk.sv
// Purpose: port checker for the byte link power and filter block
// Assumes: one clock, synchronous active-low reset
// Notes:   control bits are tracked from bus writes
`timescale 1ns/10ps
module blpf_link_power_chk
  import blpf_pkg::*;
#(
  parameter int FILT_DIV = 48,
  parameter int IDLE_CYC = BLPF_IDLE_CYC
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // register bus
  input wire logic [1:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // power events
  input wire logic        cpu_wait_exec,
  input wire logic        cpu_stop_exec,
  input wire logic        wake_irq,
  input wire logic        wake_nmi,
  input wire logic        link_clk_run,
  // link side
  input wire logic        tx_data_int,
  input wire logic        rx_filtered,
  input wire logic        tx_digital_out,
  input wire logic        rx_digital_in
);
  localparam int RUN_MAX = 17 * FILT_DIV;
  localparam int RUN_MIN = 13 * FILT_DIV;
  logic        sel_q, dl_q, al_q, wait_q;
  logic [15:0] hi_q, lo_q;
  // ****************************************
  // helper state
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
      dl_q  <= 1'b0;
      al_q  <= 1'b0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == BLPF_ADDR_CTRL1) sel_q <= avs_writedata[BLPF_C1_WAIT_SEL];
      if (avs_address == BLPF_ADDR_CTRL2) dl_q <= avs_writedata[BLPF_C2_DIGITAL_LOOP_SELECT];
      if (avs_address == BLPF_ADDR_CTRL2) al_q <= avs_writedata[BLPF_C2_ANALOG_LOOP_SELECT];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b || wake_irq) wait_q <= 1'b0;
    else if (cpu_wait_exec && !sel_q && link_clk_run) wait_q <= 1'b1;
  end
  // run lengths only count while the filter input is the pin and clocks run
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !rx_digital_in || dl_q || !link_clk_run) hi_q <= 16'h0;
    else if (hi_q != 16'hFFFF) hi_q <= hi_q + 16'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b || rx_digital_in || dl_q || !link_clk_run) lo_q <= 16'h0;
    else if (lo_q != 16'hFFFF) lo_q <= lo_q + 16'h1;
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wake_edge;
    $rose(rx_digital_in) && !dl_q && !al_q;
  endsequence
  property p_stop_entry;
    (cpu_wait_exec || cpu_stop_exec) && sel_q && link_clk_run |=> !link_clk_run;
  endproperty
  property p_wait_quiet;
    wait_q |-> !tx_digital_out;
  endproperty
  property p_digital_loop_select_quiet;
    dl_q |-> !tx_digital_out;
  endproperty
  property p_nmi_wake;
    s_wake_edge ##0 !link_clk_run |-> ##[1:3] wake_nmi;
  endproperty
  property p_irq_wake;
    s_wake_edge ##0 wait_q |-> ##[1:3] wake_irq;
  endproperty
  property p_no_wake_loop;
    $rose(rx_digital_in) && (dl_q || al_q) |-> ##1 (!wake_irq && !wake_nmi) [*3];
  endproperty
  property p_rise_min;
    $rose(rx_filtered) && !dl_q |-> hi_q >= RUN_MIN;
  endproperty
  property p_rise_max;
    hi_q == RUN_MAX |-> rx_filtered;
  endproperty
  property p_fall_max;
    lo_q == RUN_MAX |-> !rx_filtered;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry missed");
  a_wait_quiet: assert property (p_wait_quiet) else $error("drive in wait");
  a_digital_loop_select_quiet: assert property (p_digital_loop_select_quiet) else $error("drive in loop");
  a_nmi_wake: assert property (p_nmi_wake) else $error("no stop wakeup");
  a_irq_wake: assert property (p_irq_wake) else $error("no wait wakeup");
  a_no_wake_loop: assert property (p_no_wake_loop) else $error("wake in loop");
  a_rise_min: assert property (p_rise_min) else $error("filter too fast");
  a_rise_max: assert property (p_rise_max) else $error("filter rise late");
  a_fall_max: assert property (p_fall_max) else $error("filter fall late");
endmodule // blpf_link_power_chk
bind blpf_link_power blpf_link_power_chk #(.FILT_DIV(FILT_DIV), .IDLE_CYC(IDLE_CYC)) u_chk (
  .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .cpu_wait_exec, .cpu_stop_exec, .wake_irq,
  .wake_nmi, .link_clk_run, .tx_data_int, .rx_filtered, .tx_digital_out, .rx_digital_in);

// file: blpf_link_power_bench.sv
// Purpose: self-checking bench for the byte link power and filter block
// Assumes: short filter divider and idle count keep the run brief
// Notes:   read results pass through an expectation queue
`timescale 1ns/10ps
module blpf_link_power_bench;
  import blpf_pkg::*;
  localparam int FD = 4;
  localparam int IC = 20;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        cpu_wait_exec = 1'b0;
  logic        cpu_stop_exec = 1'b0;
  logic        tx_data_int = 1'b0;
  logic        bus_act = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] avs_readdata, seed = 32'd82259;
  logic        avs_waitrequest, wake_irq, wake_nmi, link_clk_run;
  logic        rx_filtered, tx_digital_out, rx_digital_in;
  logic [31:0] exp_q[$], msk_q[$];
  int          error_cnt = 0, check_count = 0, irq_n = 0, nmi_n = 0, n;
  always #10 ref_clk = ~ref_clk;
  blpf_link_power #(.FILT_DIV(FD), .IDLE_CYC(IC)) DUT (.ref_clk, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_wait_exec,
    .cpu_stop_exec, .wake_irq, .wake_nmi, .link_clk_run, .tx_data_int, .rx_filtered,
    .tx_digital_out, .rx_digital_in);
  blpf_xcvr_model u_xcvr (.ref_clk, .bus_act, .slow, .tx_digital_out, .rx_digital_in);
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic clk(input int c);
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic cmp_sig(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    cmp_sig(g, e);
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest === 1'b1);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest === 1'b1);
    avs_read <= 1'b0;
  endtask
  task automatic cpu_op(input logic stp);
    @(posedge ref_clk);
    cpu_wait_exec <= !stp;
    cpu_stop_exec <= stp;
    @(posedge ref_clk);
    cpu_wait_exec <= 1'b0;
    cpu_stop_exec <= 1'b0;
  endtask
  task automatic bus(input logic v, input int c);
    @(posedge ref_clk);
    bus_act <= v;
    clk(c);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ****************************************
  // monitors and sequence
  // ****************************************
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) cmp_rd(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
    if (wake_irq === 1'b1) irq_n++;
    if (wake_nmi === 1'b1) nmi_n++;
  end
  initial begin
    #200_000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    clk(2);
    rst_b <= 1'b1;
    rd(BLPF_ADDR_STATUS, 32'h0, 32'hF7);
    wr(BLPF_ADDR_CTRL1, 32'h0);
    cpu_op(1'b0);
    rd(BLPF_ADDR_STATUS, 32'h1, 32'h3);
    #1 cmp_sig(link_clk_run, 32'h1);
    bus(1'b1, 6);
    #1 cmp_sig(32'(irq_n), 32'h1);
    rd(BLPF_ADDR_STATUS, 32'h0, 32'h3);
    clk(17 * FD);
    #1 cmp_sig(rx_filtered, 32'h1);
    bus(1'b0, 20 * FD);
    wr(BLPF_ADDR_CTRL1, 32'h1);
    for (int i = 0; i < 2; i++) begin
      rd(BLPF_ADDR_VECTOR, 32'h0, 32'hFF);
      cpu_op(i[0]);
      #1 cmp_sig(link_clk_run, 32'h0);
      bus(1'b1, 6);
      #1 cmp_sig(32'(nmi_n), 32'(i + 1));
      rd(BLPF_ADDR_VECTOR, 32'h20, 32'hFF);
      rd(BLPF_ADDR_VECTOR, 32'h0, 32'hFF);
      rd(BLPF_ADDR_CTRL1, 32'h1, 32'h1);
      bus(1'b0, 20 * FD);
    end
    wr(BLPF_ADDR_CTRL1, 32'h0);
    for (int i = 1; i < 3; i++) begin
      wr(BLPF_ADDR_CTRL2, 32'(i));
      cpu_op(1'b0);
      bus(1'b1, 6);
      #1 cmp_sig(32'(irq_n), 32'(i));
      rd(BLPF_ADDR_STATUS, 32'h1, 32'h3);
      bus(1'b0, 20 * FD);
      wr(BLPF_ADDR_CTRL2, 32'h0);
      bus(1'b1, 6);
      rd(BLPF_ADDR_STATUS, 32'h0, 32'h3);
      bus(1'b0, 20 * FD);
    end
    wr(BLPF_ADDR_CTRL2, 32'h1);
    tx_data_int <= 1'b1;
    clk(17 * FD);
    #1 cmp_sig({tx_digital_out, rx_filtered}, 32'h1);
    @(posedge ref_clk);
    tx_data_int <= 1'b0;
    clk(17 * FD);
    wr(BLPF_ADDR_CTRL2, 32'h2);
    tx_data_int <= 1'b1;
    #1 cmp_sig(tx_digital_out, 32'h1);
    rd(BLPF_ADDR_STATUS, 32'h0, 32'h8);
    tx_data_int <= 1'b0;
    wr(BLPF_ADDR_CTRL2, 32'h0);
    rd(BLPF_ADDR_STATUS, 32'h0, 32'h8);
    tx_data_int <= 1'b1;
    #1 cmp_sig(tx_digital_out, 32'h0);
    @(posedge ref_clk);
    tx_data_int <= 1'b0;
    clk(IC + 4 * FD);
    rd(BLPF_ADDR_STATUS, 32'h8, 32'h8);
    // random noise narrower than the filter delay must vanish
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      bus(1'b1, 1 + int'(xs() % (13 * FD)));
      bus(1'b0, 17 * FD);
      #1 cmp_sig(rx_filtered, 32'h0);
    end
    slow <= 1'b0;
    bus(1'b1, 0);
    n = 0;
    while (rx_filtered !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    cmp_sig(32'(n >= 15 * FD && n <= 16 * FD + 3), 32'h1);
    bus(1'b0, 20 * FD);
    #1 cmp_sig(rx_filtered, 32'h0);
    report_and_stop();
  end
endmodule // blpf_link_power_bench
